//--- rpc_pkg.sv
// Package: constants and types of the partition configuration register bank
package rpc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] CAP_OFS = 12'h130;
  localparam logic [11:0] SELF_OFS = 12'h138;
  localparam logic [11:0] BYP_OFS = 12'h13c;
  localparam logic [11:0] VMSEL_OFS = 12'h180;
  localparam logic [11:0] CQID_OFS = 12'h190;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int UPD_BIT = 31;
  localparam int MG_LSB = 16;
  localparam int PID_LSB = 0;
  localparam int NUMP_LSB = 24;
  localparam int NUMQ_LSB = 16;
  // ----------------------------------------
  // Capabilities, fixed at build time
  // ----------------------------------------
  localparam logic PART_PRESENT = 1'b1;
  localparam logic VX_PRESENT = 1'b1;
  localparam logic CQ_PRESENT = 1'b1;
  localparam logic WIDE_VM = 1'b0;
  localparam logic [7:0] MG_LIMIT = 8'h0f;
  localparam logic [15:0] PID_LIMIT = 16'h00ff;
  // Both log2 counts must stay at or below 8
  localparam logic [3:0] NUMP_LOG2 = 4'h2;
  localparam logic [3:0] NUMQ_LOG2 = 4'h1;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] MG_RST = 8'h00;
  localparam logic [15:0] PID_RST = 16'h0000;
  localparam logic [15:0] VM_RST = 16'h0000;
  // Ones up to and including the highest set bit of a limit
  function automatic logic [15:0] width_mask(input logic [15:0] lim);
    logic [15:0] m;
    m = lim;
    for (int i = 1; i < 16; i = i * 2) begin
      m = m | (m >> i);
    end
    return m;
  endfunction
  localparam logic [7:0] MG_MASK = 8'(width_mask({8'h00, MG_LIMIT}));
  localparam logic [15:0] PID_MASK = width_mask(PID_LIMIT);
  localparam logic [15:0] VM_MASK = WIDE_VM ? 16'hffff : 16'h00ff;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {RPC_UPD_IDLE, RPC_UPD_PENDING} rpc_upd_state_e;
  typedef enum logic [1:0] {
    RPC_L1_FETCH, RPC_STE_FETCH, RPC_QUEUE, RPC_MSI
  } rpc_own_kind_e;
endpackage

//--- rpc_regs.sv
// Top of the partition configuration register bank
//
// Overview of operation
// R1: Global register holds monitor group 23:16, partition id 15:0, reset zero.
// R2: Global tags apply to descriptor, entry, queue and interrupt accesses.
// R3: Update flag bit 31 resets 0; writes ignored while it is set.
// R4: New values accepted only when the same write sets the flag.
// R5: Accepted values read back at once, even before update completes.
// R6: Flag clears only once the new values are in force.
// R7: Field bits above supported width read zero and ignore writes.
// R8: Tag values above the advertised maximum give any tag.
// R9: Bypass register: monitor group 23:16, partition id 15:0, both reset zero.
// R10: Bypass tags when interface disabled, or translated with check off.
// R11: Enabled interface takes untranslated tags from entry and descriptor.
// R12: Selector holds 16-bit vm tag; upper byte zero when narrow.
// R13: Virtual request denied if untagged or stage2 tag differs.
// R14: Selector read-only while run bit set; writable otherwise.
// R15: Ident bits 27:24 give log2 control pages, at most 8.
// R16: Ident bits 19:16 give log2 queues per page; rest zero.
// R17: Absent register reads zero and ignores writes.
// R18: Capability register at 0x130 is read-only, reports maxima.
// R19: Capability holds monitor limit 23:16, partition limit 15:0.
// R20: Pending update completes promptly once old tags drain.
`timescale 1ns/10ps
module rpc_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register access
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  // Old tags still in flight
  input wire logic self_old_busy,
  input wire logic byp_old_busy,
  // Global configuration
  input wire logic interface_enable,
  input wire logic translated_check,
  // Client transactions
  input wire logic cli_valid,
  input wire logic cli_translated,
  input wire logic [7:0] cli_cfg_mg,
  input wire logic [15:0] cli_cfg_pid,
  output logic cli_tag_valid,
  output logic cli_bypass,
  output logic [7:0] cli_mg,
  output logic [15:0] cli_pid,
  // Self-originated transactions
  input wire logic own_valid,
  input wire rpc_pkg::rpc_own_kind_e own_kind,
  output logic own_tag_valid,
  output rpc_pkg::rpc_own_kind_e own_tag_kind,
  output logic [7:0] own_mg,
  output logic [15:0] own_pid,
  // Virtual translation requests
  input wire logic vx_run,
  input wire logic vx_req,
  input wire logic vx_ste_vm_tagged,
  input wire logic [15:0] vx_stage2_vm_tag,
  output logic vx_answer,
  output logic vx_deny
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // An absent register never decodes, so it reads zero and drops writes
  function automatic logic hit(
    input logic [11:0] a,
    input logic [11:0] ofs,
    input logic present
  );
    return present && (a == ofs);
  endfunction

  logic wr;
  logic rd;
  logic [15:0] vm_sel;
  logic [15:0] next_vm_sel;
  logic next_ack;
  logic [31:0] next_rdata;
  logic next_answer;
  logic next_deny;

  assign wr = reg_req && reg_write;
  assign rd = reg_req && !reg_write;

  // One select per register; an absent register never selects
  logic sel_cap;
  logic sel_self;
  logic sel_byp;
  logic sel_vm;
  logic sel_cq;

  assign sel_cap = hit(reg_addr, rpc_pkg::CAP_OFS, rpc_pkg::PART_PRESENT); // R17
  assign sel_self = hit(reg_addr, rpc_pkg::SELF_OFS, rpc_pkg::PART_PRESENT); // R17
  assign sel_byp = hit(reg_addr, rpc_pkg::BYP_OFS, rpc_pkg::PART_PRESENT); // R17
  assign sel_vm = hit(reg_addr, rpc_pkg::VMSEL_OFS, rpc_pkg::VX_PRESENT); // R17
  assign sel_cq = hit(reg_addr, rpc_pkg::CQID_OFS, rpc_pkg::CQ_PRESENT); // R17

  // ----------------------------------------
  // Partition registers
  // ----------------------------------------
  rpc_slot_if gbl_if();
  rpc_slot_if byp_if();

  assign gbl_if.wr_en = wr && sel_self;
  assign gbl_if.wdata = reg_wdata;
  assign gbl_if.busy = self_old_busy;
  assign byp_if.wr_en = wr && sel_byp;
  assign byp_if.wdata = reg_wdata;
  assign byp_if.busy = byp_old_busy;

  rpc_update_slot u_self (
    .clk(clk),
    .srst(srst),
    .s(gbl_if.slot)
  );

  rpc_update_slot u_byp (
    .clk(clk),
    .srst(srst),
    .s(byp_if.slot)
  );

  rpc_tag_route u_route (
    .clk(clk),
    .srst(srst),
    .gbl(gbl_if.user),
    .byp(byp_if.user),
    .interface_enable(interface_enable),
    .translated_check(translated_check),
    .cli_valid(cli_valid),
    .cli_translated(cli_translated),
    .cli_cfg_mg(cli_cfg_mg),
    .cli_cfg_pid(cli_cfg_pid),
    .cli_tag_valid(cli_tag_valid),
    .cli_bypass(cli_bypass),
    .cli_mg(cli_mg),
    .cli_pid(cli_pid),
    .own_valid(own_valid),
    .own_kind(own_kind),
    .own_tag_valid(own_tag_valid),
    .own_tag_kind(own_tag_kind),
    .own_mg(own_mg),
    .own_pid(own_pid)
  );

  // ----------------------------------------
  // Read path and selector
  // ----------------------------------------
  // Writes and unmapped reads answer zero; every request is acknowledged
  always_comb begin
    next_ack = reg_req;
    next_rdata = 32'h0000_0000;
    if (rd) begin
      if (sel_cap) begin
        next_rdata = {8'h00, rpc_pkg::MG_LIMIT, rpc_pkg::PID_LIMIT}; // R18 R19
      end else if (sel_self) begin
        next_rdata = gbl_if.rdata; // R5
      end else if (sel_byp) begin
        next_rdata = byp_if.rdata; // R9
      end else if (sel_vm) begin
        next_rdata = {16'h0000, vm_sel};
      end else if (sel_cq) begin
        next_rdata[rpc_pkg::NUMP_LSB +: 4] = rpc_pkg::NUMP_LOG2; // R15
        next_rdata[rpc_pkg::NUMQ_LSB +: 4] = rpc_pkg::NUMQ_LOG2; // R16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_ack <= next_ack;
      reg_rdata <= next_rdata;
    end
  end

  // Writes while a request runs are dropped, not held back for later
  always_comb begin
    next_vm_sel = vm_sel;
    if (wr && !vx_run && sel_vm) begin // R14
      next_vm_sel = reg_wdata[15:0] & rpc_pkg::VM_MASK; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vm_sel <= rpc_pkg::VM_RST;
    end else begin
      vm_sel <= next_vm_sel;
    end
  end

  // ----------------------------------------
  // Virtual request check
  // ----------------------------------------
  always_comb begin
    next_answer = vx_req;
    next_deny = vx_req && (!vx_ste_vm_tagged || vx_stage2_vm_tag != vm_sel); // R13
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      vx_answer <= 1'b0;
      vx_deny <= 1'b0;
    end else begin
      vx_answer <= next_answer;
      vx_deny <= next_deny;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_ack;
    @(posedge clk) disable iff (srst) reg_req |=> reg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged"); // R17

  property p_cap;
    @(posedge clk) disable iff (srst)
      rd && reg_addr == 12'h130 |=> reg_rdata == {8'h00, rpc_pkg::MG_LIMIT, rpc_pkg::PID_LIMIT};
  endproperty
  a_cap: assert property (p_cap) else $error("capability read wrong"); // R18

  property p_cqid;
    @(posedge clk) disable iff (srst)
      rd && reg_addr == 12'h190 |=> reg_rdata[31:28] == 4'h0 && reg_rdata[23:20] == 4'h0
        && reg_rdata[15:0] == 16'h0000 && reg_rdata[27:24] <= 4'h8 && reg_rdata[19:16] <= 4'h8;
  endproperty
  a_cqid: assert property (p_cqid) else $error("queue ident read wrong"); // R16

  property p_reset_read;
    @(posedge clk) srst ##1 !srst && !reg_req ##1 rd && !srst && reg_addr == 12'h13c
      |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("bypass reset not zero"); // R9

  property p_vm_guard;
    @(posedge clk) disable iff (srst) vx_run |=> $stable(vm_sel);
  endproperty
  a_vm_guard: assert property (p_vm_guard) else $error("selector changed while running"); // R14

  property p_vm_write;
    @(posedge clk) disable iff (srst)
      wr && !vx_run && reg_addr == 12'h180 |=> vm_sel == ($past(reg_wdata[15:0]) & rpc_pkg::VM_MASK);
  endproperty
  a_vm_write: assert property (p_vm_write) else $error("selector write lost"); // R12

  property p_deny;
    @(posedge clk) disable iff (srst)
      vx_req && vx_ste_vm_tagged && vx_stage2_vm_tag == vm_sel ##1 vx_answer |-> !vx_deny;
  endproperty
  a_deny: assert property (p_deny) else $error("matching request denied"); // R13

  property p_deny_untagged;
    @(posedge clk) disable iff (srst) vx_req && !vx_ste_vm_tagged |=> vx_answer && vx_deny;
  endproperty
  a_deny_untagged: assert property (p_deny_untagged) else $error("untagged request allowed"); // R13

  property p_unmapped;
    @(posedge clk) disable iff (srst) rd && reg_addr == 12'h134 |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // R17

  property p_self_read;
    @(posedge clk) disable iff (srst)
      rd && reg_addr == 12'h138 |=> reg_rdata == $past(gbl_if.rdata);
  endproperty
  a_self_read: assert property (p_self_read) else $error("global register read wrong"); // R5

  property p_byp_read;
    @(posedge clk) disable iff (srst)
      rd && reg_addr == 12'h13c |=> reg_rdata == $past(byp_if.rdata);
  endproperty
  a_byp_read: assert property (p_byp_read) else $error("bypass register read wrong"); // R9

  property p_sel_read;
    @(posedge clk) disable iff (srst)
      rd && reg_addr == 12'h180 |=> reg_rdata == {16'h0000, $past(vm_sel) & rpc_pkg::VM_MASK};
  endproperty
  a_sel_read: assert property (p_sel_read) else $error("selector read wrong"); // R12

  property p_self_done;
    @(posedge clk) disable iff (srst) gbl_if.pending && !self_old_busy |=> !gbl_if.pending;
  endproperty
  a_self_done: assert property (p_self_done) else $error("global update not completed"); // R20

  property p_byp_done;
    @(posedge clk) disable iff (srst) byp_if.pending && !byp_old_busy |=> !byp_if.pending;
  endproperty
  a_byp_done: assert property (p_byp_done) else $error("bypass update not completed"); // R20

  c_vx_allow: cover property (@(posedge clk) disable iff (srst) vx_answer && !vx_deny);
  c_self_update: cover property (@(posedge clk) disable iff (srst)
    gbl_if.wr_en && reg_wdata[31] ##1 gbl_if.pending ##[1:8] !gbl_if.pending);
  c_write_while_run: cover property (@(posedge clk) disable iff (srst)
    wr && vx_run && reg_addr == 12'h180);
endmodule // rpc_regs

//--- rpc_slot_if.sv
// Interface: one partition register slot and its users
`timescale 1ns/10ps
interface rpc_slot_if;
  logic wr_en;
  logic [31:0] wdata;
  logic busy;
  logic [31:0] rdata;
  logic pending;
  logic [7:0] active_mg;
  logic [15:0] active_pid;
  modport owner (output wr_en, output wdata, output busy, input rdata, input pending);
  modport slot (input wr_en, input wdata, input busy, output rdata, output pending,
                output active_mg, output active_pid);
  modport user (input active_mg, input active_pid);
endinterface // rpc_slot_if

//--- rpc_tag_route.sv
// Picks the partition tags for client and self-originated transactions
`timescale 1ns/10ps
module rpc_tag_route (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Values in force
  rpc_slot_if.user gbl,
  rpc_slot_if.user byp,
  // Global configuration
  input wire logic interface_enable,
  input wire logic translated_check,
  // Client transactions
  input wire logic cli_valid,
  input wire logic cli_translated,
  input wire logic [7:0] cli_cfg_mg,
  input wire logic [15:0] cli_cfg_pid,
  output logic cli_tag_valid,
  output logic cli_bypass,
  output logic [7:0] cli_mg,
  output logic [15:0] cli_pid,
  // Self-originated transactions
  input wire logic own_valid,
  input wire rpc_pkg::rpc_own_kind_e own_kind,
  output logic own_tag_valid,
  output rpc_pkg::rpc_own_kind_e own_tag_kind,
  output logic [7:0] own_mg,
  output logic [15:0] own_pid
);
  logic next_bypass;

  always_comb begin
    next_bypass = !interface_enable || (cli_translated && !translated_check); // R10
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cli_tag_valid <= 1'b0;
      cli_bypass <= 1'b0;
      cli_mg <= 8'h00;
      cli_pid <= 16'h0000;
      own_tag_valid <= 1'b0;
      own_tag_kind <= rpc_pkg::RPC_L1_FETCH;
      own_mg <= 8'h00;
      own_pid <= 16'h0000;
    end else begin
      cli_tag_valid <= cli_valid;
      cli_bypass <= next_bypass;
      cli_mg <= next_bypass ? byp.active_mg : cli_cfg_mg; // R10 R11
      cli_pid <= next_bypass ? byp.active_pid : cli_cfg_pid; // R11
      // Every kind of own access takes the global tags
      own_tag_valid <= own_valid; // R2
      own_tag_kind <= own_kind;
      own_mg <= gbl.active_mg;
      own_pid <= gbl.active_pid;
    end
  end

  property p_bypass;
    @(posedge clk) disable iff (srst)
      cli_valid && !interface_enable |=> cli_bypass && cli_pid == $past(byp.active_pid);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass tags not used"); // R10
  property p_cfg;
    @(posedge clk) disable iff (srst)
      cli_valid && interface_enable && !cli_translated |=> !cli_bypass && cli_mg == $past(cli_cfg_mg);
  endproperty
  a_cfg: assert property (p_cfg) else $error("configured tags not used"); // R11
  property p_own;
    @(posedge clk) disable iff (srst)
      own_valid |=> own_tag_valid && own_pid == $past(gbl.active_pid) && own_mg == $past(gbl.active_mg);
  endproperty
  a_own: assert property (p_own) else $error("own access tags wrong"); // R2
  c_translated: cover property (@(posedge clk) disable iff (srst)
    cli_valid && interface_enable && cli_translated && !translated_check);
endmodule // rpc_tag_route

//--- rpc_update_slot.sv
// Partition register with update flag: shown values and values in force
`timescale 1ns/10ps
module rpc_update_slot (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register side
  rpc_slot_if.slot s
);
  rpc_pkg::rpc_upd_state_e state, next_state;
  logic [7:0] mg, next_mg, act_mg, next_act_mg;
  logic [15:0] pid, next_pid, act_pid, next_act_pid;
  logic accept;

  always_comb begin
    accept = 1'b0;
    next_state = state;
    next_mg = mg;
    next_pid = pid;
    next_act_mg = act_mg;
    next_act_pid = act_pid;
    case (state)
      rpc_pkg::RPC_UPD_IDLE: begin
        // A write that leaves the flag clear changes nothing
        if (s.wr_en && s.wdata[rpc_pkg::UPD_BIT]) begin // R4
          accept = 1'b1;
          next_state = rpc_pkg::RPC_UPD_PENDING;
          next_mg = s.wdata[rpc_pkg::MG_LSB +: 8] & rpc_pkg::MG_MASK; // R7 R8
          next_pid = s.wdata[rpc_pkg::PID_LSB +: 16] & rpc_pkg::PID_MASK; // R7
        end
      end
      rpc_pkg::RPC_UPD_PENDING: begin
        // Writes are dropped here; swap once old tags have drained
        if (!s.busy) begin // R3 R20
          next_state = rpc_pkg::RPC_UPD_IDLE;
          next_act_mg = mg; // R6
          next_act_pid = pid;
        end
      end
      default: next_state = rpc_pkg::RPC_UPD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= rpc_pkg::RPC_UPD_IDLE; // R3
      mg <= rpc_pkg::MG_RST; // R1 R9
      pid <= rpc_pkg::PID_RST;
      act_mg <= rpc_pkg::MG_RST;
      act_pid <= rpc_pkg::PID_RST;
    end else begin
      state <= next_state;
      mg <= next_mg;
      pid <= next_pid;
      act_mg <= next_act_mg;
      act_pid <= next_act_pid;
    end
  end

  assign s.pending = (state == rpc_pkg::RPC_UPD_PENDING);
  assign s.rdata = {s.pending, 7'h00, mg, pid}; // R5
  assign s.active_mg = act_mg;
  assign s.active_pid = act_pid;

  property p_slot_reset;
    @(posedge clk) srst |=> !s.pending && mg == 8'h00 && pid == 16'h0000 && act_pid == 16'h0000;
  endproperty
  a_slot_reset: assert property (p_slot_reset) else $error("slot reset values wrong"); // R1
  property p_pending_locked;
    @(posedge clk) disable iff (srst) s.pending |=> $stable(mg) && $stable(pid);
  endproperty
  a_pending_locked: assert property (p_pending_locked) else $error("write taken while pending"); // R3
  property p_no_flag_ignored;
    @(posedge clk) disable iff (srst)
      !s.pending && s.wr_en && !s.wdata[31] |=> !s.pending && $stable(mg) && $stable(pid);
  endproperty
  a_no_flag_ignored: assert property (p_no_flag_ignored) else $error("flagless write taken"); // R4
  property p_visible;
    @(posedge clk) disable iff (srst)
      accept |=> s.rdata[31] && s.rdata[23:16] == ($past(s.wdata[23:16]) & rpc_pkg::MG_MASK)
        && s.rdata[15:0] == ($past(s.wdata[15:0]) & rpc_pkg::PID_MASK);
  endproperty
  a_visible: assert property (p_visible) else $error("new value not readable"); // R5
  property p_swap;
    @(posedge clk) disable iff (srst)
      s.pending && !s.busy |=> !s.pending && act_mg == $past(mg) && act_pid == $past(pid);
  endproperty
  a_swap: assert property (p_swap) else $error("update not completed"); // R6
  property p_hold_old;
    @(posedge clk) disable iff (srst) s.pending && s.busy |=> $stable(act_mg) && $stable(act_pid);
  endproperty
  a_hold_old: assert property (p_hold_old) else $error("values swapped while busy"); // R20
  property p_narrow;
    @(posedge clk) disable iff (srst) (mg & ~rpc_pkg::MG_MASK) == 8'h00 && (pid & ~rpc_pkg::PID_MASK) == 16'h0000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("unsupported field bits set"); // R7
  c_update: cover property (@(posedge clk) disable iff (srst) accept ##1 s.busy ##[1:4] !s.pending);
endmodule // rpc_update_slot

//--- tb_rpc_regs.sv
// Self-checking testbench of the partition configuration register bank
`timescale 1ns/10ps
module tb_rpc_regs;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_write = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_ack;
  logic [31:0] reg_rdata;
  logic self_old_busy = 1'b0;
  logic byp_old_busy = 1'b0;
  logic interface_enable = 1'b1;
  logic translated_check = 1'b0;
  logic cli_valid = 1'b0;
  logic cli_translated = 1'b0;
  logic [7:0] cli_cfg_mg = 8'h00;
  logic [15:0] cli_cfg_pid = 16'h0000;
  logic cli_tag_valid;
  logic cli_bypass;
  logic [7:0] cli_mg;
  logic [15:0] cli_pid;
  logic own_valid = 1'b0;
  rpc_pkg::rpc_own_kind_e own_kind = rpc_pkg::RPC_L1_FETCH;
  logic own_tag_valid;
  rpc_pkg::rpc_own_kind_e own_tag_kind;
  logic [7:0] own_mg;
  logic [15:0] own_pid;
  logic vx_run = 1'b0;
  logic vx_req = 1'b0;
  logic vx_ste_vm_tagged = 1'b0;
  logic [15:0] vx_stage2_vm_tag = 16'h0000;
  logic vx_answer;
  logic vx_deny;
  logic [31:0] q_reg[$];
  logic [31:0] q_cli[$];
  logic [31:0] q_own[$];
  logic [31:0] q_vx[$];
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  // Ones up to the highest set bit of a limit
  function automatic logic [15:0] fmask(input logic [15:0] lim);
    fmask = 16'h0;
    for (int i = 0; i < 16; i++) begin
      if ((lim >> i) != 16'h0) fmask[i] = 1'b1;
    end
  endfunction
  localparam logic [15:0] MG_M = fmask({8'h00, rpc_pkg::MG_LIMIT});
  localparam logic [15:0] PID_M = fmask(rpc_pkg::PID_LIMIT);

  always #20 clk = ~clk;

  rpc_regs i_dut (
    .clk(clk), .srst(srst), .reg_req(reg_req), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
    .self_old_busy(self_old_busy), .byp_old_busy(byp_old_busy),
    .interface_enable(interface_enable), .translated_check(translated_check),
    .cli_valid(cli_valid), .cli_translated(cli_translated), .cli_cfg_mg(cli_cfg_mg),
    .cli_cfg_pid(cli_cfg_pid), .cli_tag_valid(cli_tag_valid), .cli_bypass(cli_bypass),
    .cli_mg(cli_mg), .cli_pid(cli_pid), .own_valid(own_valid), .own_kind(own_kind),
    .own_tag_valid(own_tag_valid), .own_tag_kind(own_tag_kind), .own_mg(own_mg),
    .own_pid(own_pid), .vx_run(vx_run), .vx_req(vx_req),
    .vx_ste_vm_tagged(vx_ste_vm_tagged), .vx_stage2_vm_tag(vx_stage2_vm_tag),
    .vx_answer(vx_answer), .vx_deny(vx_deny)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // An answer with no note left compares against unknown and fails
  always @(posedge clk) begin
    if (reg_ack === 1'b1) cmp(reg_rdata, q_reg.size() > 0 ? q_reg.pop_front() : 'x);
    if (cli_tag_valid === 1'b1)
      cmp({7'h0, cli_bypass, cli_mg, cli_pid}, q_cli.size() > 0 ? q_cli.pop_front() : 'x);
    if (own_tag_valid === 1'b1)
      cmp({6'h0, own_tag_kind, own_mg, own_pid}, q_own.size() > 0 ? q_own.pop_front() : 'x);
    if (vx_answer === 1'b1) cmp({31'h0, vx_deny}, q_vx.size() > 0 ? q_vx.pop_front() : 'x);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk);
    reg_req <= 1'b1;
    reg_write <= w;
    reg_addr <= a;
    reg_wdata <= d;
    q_reg.push_back(w ? 32'h0 : e);
    @(posedge clk);
    reg_req <= 1'b0;
  endtask

  task automatic cli(input logic tr, input logic [23:0] bv);
    logic b;
    @(posedge clk);
    b = !interface_enable || (tr && !translated_check);
    cli_valid <= 1'b1;
    cli_translated <= tr;
    q_cli.push_back(b ? {8'h01, bv} : {8'h00, cli_cfg_mg, cli_cfg_pid});
    @(posedge clk);
    cli_valid <= 1'b0;
  endtask

  // All four kinds back to back
  task automatic own_all(input logic [23:0] v);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      own_valid <= 1'b1;
      own_kind <= rpc_pkg::rpc_own_kind_e'(k);
      q_own.push_back({6'h0, 2'(k), v});
    end
    @(posedge clk);
    own_valid <= 1'b0;
  endtask

  task automatic vx(input logic tg, input logic [15:0] t, input logic dn);
    @(posedge clk);
    vx_req <= 1'b1;
    vx_ste_vm_tagged <= tg;
    vx_stage2_vm_tag <= t;
    q_vx.push_back({31'h0, dn});
    @(posedge clk);
    vx_req <= 1'b0;
  endtask

  task automatic tags(input logic isb, input logic [23:0] v);
    if (isb) cli(1'b0, v);
    else own_all(v);
  endtask

  // Update handshake on one partition register, old tags held in flight
  task automatic upd(input logic [11:0] a, input logic isb, inout logic [23:0] cur);
    logic [31:0] d;
    logic [23:0] nv;
    d = $urandom;
    nv = {d[23:16] & MG_M[7:0], d[15:0] & PID_M};
    acc(1'b1, a, d & 32'h7fff_ffff, 32'h0);
    acc(1'b0, a, d, {8'h00, cur});
    self_old_busy <= !isb;
    byp_old_busy <= isb;
    acc(1'b1, a, d | 32'h8000_0000, 32'h0);
    acc(1'b0, a, d, {8'h80, nv});
    acc(1'b1, a, ~d | 32'h8000_0000, 32'h0);
    acc(1'b0, a, d, {8'h80, nv});
    tags(isb, cur);
    self_old_busy <= 1'b0;
    byp_old_busy <= 1'b0;
    repeat (3) @(posedge clk);
    acc(1'b0, a, d, {8'h00, nv});
    tags(isb, nv);
    cur = nv;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [23:0] sv;
    logic [23:0] bv;
    logic [15:0] s;
    sv = 24'h0;
    bv = 24'h0;
    void'($urandom(32'h3021));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    cli_cfg_mg <= 8'($urandom);
    cli_cfg_pid <= 16'($urandom);
    acc(1'b0, rpc_pkg::BYP_OFS, 0, 32'h0);
    for (int i = 0; i < 2; i++) begin
      acc(1'b0, rpc_pkg::CAP_OFS, 0, {8'h00, rpc_pkg::MG_LIMIT, rpc_pkg::PID_LIMIT});
      acc(1'b0, rpc_pkg::CQID_OFS, 0,
          {4'h0, rpc_pkg::NUMP_LOG2, 4'h0, rpc_pkg::NUMQ_LOG2, 16'h0});
      acc(1'b0, 12'h134, 0, 32'h0);
      acc(1'b1, rpc_pkg::CAP_OFS, $urandom, 32'h0);
      acc(1'b1, rpc_pkg::CQID_OFS, $urandom, 32'h0);
      acc(1'b1, 12'h134, $urandom, 32'h0);
    end
    acc(1'b0, rpc_pkg::SELF_OFS, 0, 32'h0);
    acc(1'b0, rpc_pkg::BYP_OFS, 0, 32'h0);
    acc(1'b0, rpc_pkg::VMSEL_OFS, 0, 32'h0);
    own_all(24'h0);
    upd(rpc_pkg::SELF_OFS, 1'b0, sv);
    upd(rpc_pkg::SELF_OFS, 1'b0, sv);
    interface_enable <= 1'b0;
    upd(rpc_pkg::BYP_OFS, 1'b1, bv);
    own_all(sv);
    interface_enable <= 1'b1;
    cli(1'b1, bv);
    cli(1'b0, bv);
    translated_check <= 1'b1;
    cli(1'b1, bv);
    cli(1'b0, bv);
    s = $urandom;
    s = s & (rpc_pkg::WIDE_VM ? 16'hffff : 16'h00ff);
    acc(1'b1, rpc_pkg::VMSEL_OFS, {16'($urandom), 16'hff00 | s}, 32'h0);
    acc(1'b0, rpc_pkg::VMSEL_OFS, 0, {16'h0, s});
    vx_run <= 1'b1;
    acc(1'b1, rpc_pkg::VMSEL_OFS, {16'h0, ~s}, 32'h0);
    acc(1'b0, rpc_pkg::VMSEL_OFS, 0, {16'h0, s});
    vx(1'b1, s, 1'b0);
    vx(1'b1, s ^ 16'h0001, 1'b1);
    vx(1'b0, s, 1'b1);
    vx_run <= 1'b0;
    repeat (3) @(posedge clk);
    fails += q_reg.size() + q_cli.size() + q_own.size() + q_vx.size();
    complete_run();
  end
endmodule // tb_rpc_regs
